/* File: logic/ncp_copro_if.sv */
// Numeric coprocessor interface: error interrupt, request gating, resets
// Summary of operation
// - Busy is decoded inside to qualify the error for the interrupt; the request gate uses the latched error.
// - Error qualified by busy is latched and drives interrupt 13.
// - The request reaches the CPU only while no error is latched.
// - A system reset asserts both coprocessor and CPU reset.
// - A write to port F1h asserts only the coprocessor reset.
// - With setup bit 6 set, port F1h writes do not reset anything.
`timescale 1ns/1ps
`default_nettype none
module ncp_copro_if (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Internally generated system reset
    input wire logic sys_reset_i,
    // I/O write strobe and address, same clock domain
    input wire logic io_wr_i,
    input wire logic [15:0] io_addr_i,
    // Setup register contents
    input wire logic [7:0] misc_setup_reg_i,
    // Coprocessor pins, asynchronous
    input wire logic copro_busy_n_i,
    input wire logic copro_error_n_i,
    input wire logic copro_operand_req_i,
    // Outputs to CPU, interrupt logic and coprocessor
    output logic irq13_o,
    output logic cpu_operand_req_o,
    output logic copro_reset_out_o,
    output logic cpu_reset_out_o
);
    ncp_pkg::ncp_copro_t pin_async;
    ncp_pkg::ncp_copro_t pin_s;
    ncp_pkg::ncp_state_t st_ff;
    ncp_pkg::ncp_state_t nxt_st;
    logic port_reset_disable;
    logic port_rst_wr;
    logic err_clr_wr;
    logic err_event;

    // Gather coprocessor pins for the synchroniser
    assign pin_async = {copro_operand_req_i, copro_error_n_i,
        copro_busy_n_i};

    // Bring the coprocessor lines onto the core clock
    ncp_sync u_sync (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .async_i(pin_async),
        .sync_o(pin_s)
    );

    // Port decode and the reset disable bit
    assign port_reset_disable =
        misc_setup_reg_i[ncp_pkg::NCP_PORT_RST_DIS_BIT];
    assign port_rst_wr = io_wr_i
        && (io_addr_i == ncp_pkg::NCP_PORT_COPRO_RST)
        && !port_reset_disable;
    assign err_clr_wr = io_wr_i
        && (io_addr_i == ncp_pkg::NCP_PORT_ERR_CLR);
    // Error counts only while the unit still reports busy
    assign err_event = !pin_s.error_n && !pin_s.busy_n;

    // Next state of the whole block
    always_comb begin
        nxt_st = st_ff;
        // Pulse counter restarts on each accepted port write
        // and counts down to zero before the reset drops
        if (port_rst_wr) begin
            nxt_st.rst_cnt_ff = ncp_pkg::NCP_RST_HOLD_CYC;
        end else if (st_ff.rst_cnt_ff != ncp_pkg::NCP_CNT_ZERO) begin
            nxt_st.rst_cnt_ff = st_ff.rst_cnt_ff - 8'h01;
        end
        // Coprocessor reset from system reset or the pulse counter
        nxt_st.copro_rst_ff = sys_reset_i
            || (nxt_st.rst_cnt_ff != ncp_pkg::NCP_CNT_ZERO);
        nxt_st.cpu_rst_ff = sys_reset_i;
        // Error latch: a new error wins over a clear in the same cycle
        // A running coprocessor reset pulse clears it as well
        if (err_event) begin
            nxt_st.err_latch_ff = 1'b1;
        end else if (err_clr_wr || st_ff.copro_rst_ff) begin
            nxt_st.err_latch_ff = 1'b0;
        end
        // Operand request blocked while the error interrupt stands
        nxt_st.op_req_ff = pin_s.operand_req
            && !st_ff.err_latch_ff;
    end

    // State register
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from flip-flops
    // so the CPU and interrupt logic never see glitches
    assign irq13_o = st_ff.err_latch_ff;
    assign cpu_operand_req_o = st_ff.op_req_ff;
    assign copro_reset_out_o = st_ff.copro_rst_ff;
    assign cpu_reset_out_o = st_ff.cpu_rst_ff;

    // Busy-qualified error raises the interrupt next cycle
    a_err_sets_irq: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (!pin_s.error_n && !pin_s.busy_n) |=> irq13_o)
        else $error("error with busy did not raise interrupt");

    // Error without busy does not start an interrupt
    a_err_needs_busy: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (!irq13_o && pin_s.busy_n) |=> !irq13_o)
        else $error("interrupt raised while coprocessor idle");

    // Request blocked during a latched error
    a_req_blocked: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        irq13_o |=> !cpu_operand_req_o)
        else $error("operand request passed during error");

    // Request forwarded when no error is latched
    a_req_passes: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (pin_s.operand_req && !irq13_o) |=> cpu_operand_req_o)
        else $error("operand request not forwarded");

    // System reset drives both reset outputs
    a_sys_rst_both: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        sys_reset_i |=> (copro_reset_out_o && cpu_reset_out_o))
        else $error("system reset missed a reset output");

    // Port write resets only the coprocessor
    a_port_rst_only: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (port_rst_wr && !sys_reset_i)
        |=> (copro_reset_out_o && !cpu_reset_out_o))
        else $error("port reset wrong outputs");

    // Disabled port write has no effect on an idle reset
    a_port_rst_off: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (io_wr_i && io_addr_i == ncp_pkg::NCP_PORT_COPRO_RST
            && port_reset_disable && !sys_reset_i
            && st_ff.rst_cnt_ff == ncp_pkg::NCP_CNT_ZERO)
        |=> !copro_reset_out_o)
        else $error("disabled port write reset the coprocessor");

    // Reset stays high while the hold counter runs
    a_rst_hold_run: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (st_ff.rst_cnt_ff > 8'h01) |=> copro_reset_out_o)
        else $error("coprocessor reset released early");

    // Port write loads the hold count and raises the reset
    a_rst_hold_len: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (port_rst_wr && !sys_reset_i)
        |=> (st_ff.rst_cnt_ff == ncp_pkg::NCP_RST_HOLD_CYC)
            && copro_reset_out_o)
        else $error("hold counter not loaded");

    // Release once the counter reaches zero without new causes
    a_rst_release: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (st_ff.rst_cnt_ff == 8'h01 && !port_rst_wr && !sys_reset_i)
        |=> !copro_reset_out_o)
        else $error("coprocessor reset not released");

    // CPU reset follows only the system reset
    a_cpu_rst_follow: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        !sys_reset_i |=> !cpu_reset_out_o)
        else $error("CPU reset raised without system reset");

    // Latched error stays until cleared or reset
    a_irq_holds: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (irq13_o && !err_clr_wr && !copro_reset_out_o) |=> irq13_o)
        else $error("interrupt dropped without a clear");

    // Clear port drops the interrupt when no error is pending
    a_err_clear: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (err_clr_wr && !err_event) |=> !irq13_o)
        else $error("interrupt not cleared by the clear port");

    // Request low at the pin keeps the CPU request low
    a_req_low: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        !pin_s.operand_req |=> !cpu_operand_req_o)
        else $error("operand request raised without coprocessor request");

    // No cause, no coprocessor reset
    a_copro_rst_idle: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (!sys_reset_i && !port_rst_wr
            && st_ff.rst_cnt_ff == ncp_pkg::NCP_CNT_ZERO)
        |=> !copro_reset_out_o)
        else $error("coprocessor reset without a cause");

    // Main scenarios
    c_error_irq: cover property (
        @(posedge core_clk_i) disable iff (!rst_n_i) $rose(irq13_o));
    c_req_fwd: cover property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        $rose(cpu_operand_req_o));
    c_port_rst: cover property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        port_rst_wr ##126 $fell(copro_reset_out_o)); // Hold count plus one
    c_sys_rst: cover property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        $rose(cpu_reset_out_o));
endmodule : ncp_copro_if
`default_nettype wire

/* File: logic/ncp_pkg.sv */
// Constants and types shared by the numeric coprocessor interface
package ncp_pkg;
    // I/O ports decoded by the block
    localparam logic [15:0] NCP_PORT_COPRO_RST = 16'h00f1;
    localparam logic [15:0] NCP_PORT_ERR_CLR = 16'h00f0;
    // Bit of the setup register that blocks the port reset
    localparam int NCP_PORT_RST_DIS_BIT = 6;
    // Clock and coprocessor reset pulse timing
    localparam int NCP_CLK_PERIOD_PS = 8000;
    localparam int NCP_RST_HOLD_NS = 1000;
    localparam logic [7:0] NCP_RST_HOLD_CYC = 8'((NCP_RST_HOLD_NS * 1000
        + NCP_CLK_PERIOD_PS - 1) / NCP_CLK_PERIOD_PS);
    // Idle levels of the synchronised inputs: {req, error_n, busy_n}
    localparam logic [2:0] NCP_SYNC_RST = 3'h3;
    localparam logic [7:0] NCP_CNT_ZERO = 8'h00;

    // Synchronised coprocessor status lines
    typedef struct packed {
        logic operand_req;
        logic error_n;
        logic busy_n;
    } ncp_copro_t;

    // Whole state of the interface block
    typedef struct packed {
        logic err_latch_ff;
        logic op_req_ff;
        logic copro_rst_ff;
        logic cpu_rst_ff;
        logic [7:0] rst_cnt_ff;
    } ncp_state_t;
endpackage : ncp_pkg

/* File: logic/ncp_sync.sv */
// Two-stage synchroniser for the coprocessor status inputs
`timescale 1ns/1ps
`default_nettype none
module ncp_sync (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Asynchronous and synchronised lines
    input wire ncp_pkg::ncp_copro_t async_i,
    output var ncp_pkg::ncp_copro_t sync_o
);
    typedef struct packed {
        logic [2:0] meta_ff;
        logic [2:0] sync_ff;
    } ncp_sync_state_t;

    ncp_sync_state_t st_ff;
    ncp_sync_state_t nxt_st;

    // Stage one feeds stage two only
    always_comb begin
        nxt_st.meta_ff = async_i;
        nxt_st.sync_ff = st_ff.meta_ff;
    end

    // State register
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff <= {ncp_pkg::NCP_SYNC_RST, ncp_pkg::NCP_SYNC_RST};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sync_o = st_ff.sync_ff;

    // Input reaches the output after exactly two edges
    a_sync_two_stage: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        ##2 (sync_o == $past(async_i, 2)))
        else $error("synchroniser delay is not two cycles");
endmodule : ncp_sync
`default_nettype wire

/* File: bench/ncp_copro_model.sv */
// Behavioural coprocessor driving busy, error and operand request
`timescale 1ns/1ps
`default_nettype none
module ncp_copro_model (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Instruction start, operand need, error mode
    input wire logic start_i,
    input wire logic need_op_i,
    input wire logic [1:0] err_mode_i,
    // Coprocessor pins
    output logic busy_n_o,
    output logic error_n_o,
    output logic operand_req_o
);
    logic [3:0] cnt_ff;
    logic [1:0] mode_ff;
    logic need_ff;
    // Instruction timer, 15 busy cycles
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_ff <= 4'h0;
            mode_ff <= 2'h0;
            need_ff <= 1'b0;
        end else if (start_i) begin
            cnt_ff <= 4'hf;
            mode_ff <= err_mode_i;
            need_ff <= need_op_i;
        end else if (cnt_ff != 4'h0) begin
            cnt_ff <= cnt_ff - 4'h1;
        end
    end
    // Pin levels; error holds until the next instruction
    assign busy_n_o = (cnt_ff == 4'h0);
    assign error_n_o = !((mode_ff == 2'h1 && cnt_ff < 4'h8)
        || (mode_ff == 2'h2 && cnt_ff == 4'h0));
    assign operand_req_o = need_ff && cnt_ff > 4'h8;
endmodule : ncp_copro_model
`default_nettype wire

/* File: bench/tb.sv */
// Self-checking bench for the coprocessor interface
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk, rst_n, sys_rst, io_wr, start, need;
    logic [15:0] io_addr;
    logic [7:0] misc;
    logic [1:0] mode;
    logic busy_n, err_n, oreq, irq, creq, crst, cpurst;
    int n_errors = 0;
    int checks_done = 0;
    localparam int HOLD = int'(ncp_pkg::NCP_RST_HOLD_CYC);
    ncp_copro_model i_cop (.core_clk_i(clk), .rst_n_i(rst_n),
        .start_i(start), .need_op_i(need), .err_mode_i(mode),
        .busy_n_o(busy_n), .error_n_o(err_n), .operand_req_o(oreq));
    ncp_copro_if i_dut (.core_clk_i(clk), .rst_n_i(rst_n),
        .sys_reset_i(sys_rst), .io_wr_i(io_wr), .io_addr_i(io_addr),
        .misc_setup_reg_i(misc), .copro_busy_n_i(busy_n),
        .copro_error_n_i(err_n), .copro_operand_req_i(oreq),
        .irq13_o(irq), .cpu_operand_req_o(creq),
        .copro_reset_out_o(crst), .cpu_reset_out_o(cpurst));
    // Clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Compare one output bit
    task automatic chk(input string name, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
        end
    endtask : chk
    // Wait edges, then settle
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // One-cycle I/O write
    task automatic io_write(input logic [15:0] a);
        @(posedge clk);
        io_wr <= 1'b1;
        io_addr <= a;
        @(posedge clk);
        io_wr <= 1'b0;
    endtask : io_write
    // Start one coprocessor instruction
    task automatic op(input logic [1:0] m, input logic nd);
        @(posedge clk);
        start <= 1'b1;
        mode <= m;
        need <= nd;
        @(posedge clk);
        start <= 1'b0;
    endtask : op
    // Error during busy raises irq, blocks requests, port clears it
    task automatic t_error_irq;
        op(2'h1, 1'b0);
        tick(9);
        chk("irq13 early", 1'b0, irq);
        tick(2);
        chk("irq13 set", 1'b1, irq);
        op(2'h0, 1'b1);
        tick(6);
        chk("req blocked", 1'b0, creq);
        tick(12);
        io_write(ncp_pkg::NCP_PORT_ERR_CLR);
        tick(2);
        chk("irq13 cleared", 1'b0, irq);
        op(2'h0, 1'b1);
        tick(6);
        chk("req passed", 1'b1, creq);
        tick(14);
    endtask : t_error_irq
    // Error while not busy never raises irq
    task automatic t_error_idle;
        op(2'h2, 1'b0);
        tick(25);
        chk("irq13 idle err", 1'b0, irq);
    endtask : t_error_idle
    // Port write resets the coprocessor only, for the hold time
    task automatic t_port_reset;
        op(2'h1, 1'b0);
        tick(19);
        chk("irq13 before port rst", 1'b1, irq);
        io_write(ncp_pkg::NCP_PORT_COPRO_RST);
        tick(2);
        chk("copro rst on", 1'b1, crst);
        chk("cpu rst idle", 1'b0, cpurst);
        chk("irq13 port rst clr", 1'b0, irq);
        tick(HOLD - 3);
        chk("copro rst held", 1'b1, crst);
        tick(1);
        chk("copro rst off", 1'b0, crst);
        op(2'h0, 1'b0);
        tick(17);
        chk("irq13 after init", 1'b0, irq);
    endtask : t_port_reset
    // Disabled port reset; system reset still works
    task automatic t_disable_sys;
        @(posedge clk);
        misc <= 8'h40;
        io_write(ncp_pkg::NCP_PORT_COPRO_RST);
        tick(3);
        chk("port rst ignored", 1'b0, crst);
        @(posedge clk);
        sys_rst <= 1'b1;
        tick(4);
        chk("sys copro rst", 1'b1, crst);
        chk("sys cpu rst", 1'b1, cpurst);
        @(posedge clk);
        sys_rst <= 1'b0;
        tick(3);
        chk("cpu rst released", 1'b0, cpurst);
        chk("copro rst released", 1'b0, crst);
        @(posedge clk);
        misc <= 8'h00;
    endtask : t_disable_sys
    // Verdict and end of run
    task automatic report_and_stop;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop
    // Watchdog, well above the expected 286 cycles
    initial begin
        #40000;
        n_errors++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        rst_n = 1'b0;
        {sys_rst, io_wr, start, need} = 4'h0;
        io_addr = 16'h0000;
        misc = 8'h00;
        mode = 2'h0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        tick(1);
        chk("irq13 reset", 1'b0, irq);
        chk("copro rst reset", 1'b0, crst);
        t_error_irq();
        t_error_idle();
        t_port_reset();
        t_disable_sys();
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
